// ===== rtl/psp_top.sv
// Press permit logic for setup operation with an AXI4-Lite register port.
// Assumes the permit inputs are asynchronous pins; aclk is 10 MHz.
`timescale 1ns/100ps
`include "psp_cfg.svh"

module psp_top #(
    parameter int ADDR_W = 12,
    parameter logic [31:0] MIN_SHORT_CYC =
        32'(`PSP_MIN_SHORT_MS * `PSP_CYC_PER_MS),
    parameter logic [31:0] MIN_LONG_CYC =
        32'(`PSP_MIN_LONG_MS * `PSP_CYC_PER_MS),
    parameter logic [31:0] MAX_PULSE_CYC =
        32'(`PSP_MAX_PULSE_MS * `PSP_CYC_PER_MS)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire psp_pkg::psp_in_t pin_in,
    output logic press_permit,
    output logic rearm_pending,
    output logic main_permit_n,
    output logic irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import psp_pkg::*;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [11:0] OFS_CTRL = `PSP_OFS_CTRL;
    localparam logic [11:0] OFS_STAT = `PSP_OFS_IRQ_STAT;
    localparam logic [11:0] OFS_MASK = `PSP_OFS_IRQ_MASK;
    localparam logic [7:0] MASK_RST = `PSP_MASK_RST;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Returns bit 2 set when mapped, low bits the register index
    function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
        logic [2:0] r;
        r = {1'b0, a[3:2]};
        if (a[ADDR_W-1:4] == '0 && a[1:0] == 2'h0) begin
            r[2] = 1'b1;
        end
        return r;
    endfunction

    // Pin synchroniser, then one more stage as the previous sample
    psp_in_t sync1_q, in_q, prev_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            in_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= pin_in;
            in_q <= sync1_q;
            prev_q <= in_q;
        end
    end

    psp_cfg_t cfg_q;
    logic [`PSP_EV_W-1:0] ev_stat_q, ev_mask_q;
    logic permit_q, lock_q, pending_q, main_n_q, irq_q;
    logic [31:0] cnt_q;

    wire run_rise = in_q.run_req & ~prev_q.run_req;
    wire run_fall = prev_q.run_req & ~in_q.run_req;
    wire main_low = ~in_q.main_ok;
    wire top_rise = cfg_q.stroke_en & in_q.stroke_end & ~prev_q.stroke_end;
    wire start_ok = ~cfg_q.start_en | in_q.start_ok;
    wire pol_none = cfg_q.policy == `PSP_POL_NONE;
    wire pol_run = cfg_q.policy == `PSP_POL_RUN_MAIN;
    wire pol_top = cfg_q.policy == `PSP_POL_TOP_MAIN;
    wire lock_eff = lock_q & ~pol_none;

    // Start-only permit gates the start and rearm_pending, never the run
    wire start = ~permit_q & ~lock_eff & in_q.main_ok & start_ok
        & run_rise;
    wire drop = permit_q & (run_fall | main_low | top_rise);
    wire permit_d = start | (permit_q & ~drop);

    // Unknown policy codes behave as always, the safe side
    wire lock_cause = pol_run ? (run_fall | main_low) :
        pol_top ? (top_rise | main_low) : ~pol_none;
    wire engage = drop & lock_cause;

    wire [31:0] min_cyc = cfg_q.long_pulse ? MIN_LONG_CYC : MIN_SHORT_CYC;
    wire rearm_fall = prev_q.rearm & ~in_q.rearm;
    wire in_window = cnt_q >= min_cyc && cnt_q <= MAX_PULSE_CYC;
    wire rearm_ok = rearm_fall & in_window;
    wire rearm_bad = rearm_fall & ~in_window;
    wire [31:0] cnt_d = !in_q.rearm ? 32'h0 :
        (cnt_q > MAX_PULSE_CYC) ? cnt_q : cnt_q + 32'h1;

    // Engage beats a same-cycle rearm so a stop is never forgotten
    wire lock_d = engage | (lock_q & ~rearm_ok);
    wire lock_eff_d = lock_d & ~pol_none;
    wire pending_d = lock_eff_d & in_q.main_ok & start_ok
        & ~permit_d;

    wire [`PSP_EV_W-1:0] ev_now = {rearm_bad, rearm_ok,
        engage & ~lock_q, drop, start};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            permit_q <= 1'b0;
            lock_q <= 1'b1;
            pending_q <= 1'b0;
            main_n_q <= 1'b1;
            cnt_q <= 32'h0;
        end else begin
            permit_q <= permit_d;
            lock_q <= lock_d;
            pending_q <= pending_d;
            main_n_q <= ~in_q.main_ok;
            cnt_q <= cnt_d;
        end
    end

    // Register port
    logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q;
    logic arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;

    wire aw_take = s_axi_awvalid & awready_q;
    wire w_take = s_axi_wvalid & wready_q;
    wire do_write = aw_hold_q & w_hold_q & ~bvalid_q;
    wire aw_hold_d = aw_take | (aw_hold_q & ~do_write);
    wire w_hold_d = w_take | (w_hold_q & ~do_write);
    wire bvalid_d = do_write | (bvalid_q & ~s_axi_bready);
    wire [2:0] wsel = decode(awaddr_q);
    wire wr_ctrl = do_write && wsel == {1'b1, OFS_CTRL[3:2]};
    wire wr_stat = do_write && wsel == {1'b1, OFS_STAT[3:2]};
    wire wr_mask = do_write && wsel == {1'b1, OFS_MASK[3:2]};
    wire [31:0] ctrl_w = merge({24'h0, cfg_q}, wdata_q, wstrb_q);
    wire [31:0] mask_w = merge({27'h0, ev_mask_q}, wdata_q, wstrb_q);
    wire [31:0] clr_w = merge(32'h0, wdata_q, wstrb_q);
    wire [`PSP_EV_W-1:0] ev_clr = wr_stat ? clr_w[`PSP_EV_W-1:0] : '0;
    wire [`PSP_EV_W-1:0] ev_stat_d = ev_now | (ev_stat_q & ~ev_clr);

    wire ar_take = s_axi_arvalid & arready_q;
    wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
    wire [2:0] rsel = decode(s_axi_araddr);
    wire [31:0] status_w = {19'h0, in_q, 4'h0, lock_q, main_n_q,
        pending_q, permit_q};
    wire [31:0] rd_word = (rsel[1:0] == 2'h0) ? {24'h0, cfg_q} :
        (rsel[1:0] == 2'h1) ? status_w :
        (rsel[1:0] == 2'h2) ? {27'h0, ev_stat_q} : {27'h0, ev_mask_q};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awready_q <= ~aw_hold_d;
            wready_q <= ~w_hold_d;
            bvalid_q <= bvalid_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                bresp_q <= wsel[2] ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else begin
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_take) begin
                rdata_q <= rsel[2] ? rd_word : 32'h0;
                rresp_q <= rsel[2] ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Policy gates the held lock at once and picks the lock cause at the next stop; pulse length at the next pulse end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= psp_cfg_t'(`PSP_CTRL_RST);
            ev_mask_q <= MASK_RST[`PSP_EV_W-1:0];
            ev_stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                cfg_q <= psp_cfg_t'({2'h0, ctrl_w[5:0]});
            end
            if (wr_mask) begin
                ev_mask_q <= mask_w[`PSP_EV_W-1:0];
            end
            ev_stat_q <= ev_stat_d;
            irq_q <= |(ev_stat_d & ev_mask_q);
        end
    end

    assign press_permit = permit_q;
    assign rearm_pending = pending_q;
    assign main_permit_n = main_n_q;
    assign irq = irq_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_stop;
        permit_q ##1 !permit_q;
    endsequence

    sequence seq_rearm_pulse;
        in_q.rearm ##1 !in_q.rearm;
    endsequence

    chk_start_gate: assert property (
        $rose(permit_q) && cfg_q.start_en |-> $past(in_q.start_ok))
        else $error("permit rose without start-only permit");

    chk_start_ignored: assert property (
        permit_q && !in_q.start_ok && !run_fall && !main_low && !top_rise
        |=> permit_q)
        else $error("start-only permit dropped a running press");

    chk_stroke_stop: assert property (
        permit_q && top_rise |=> !permit_q)
        else $error("stroke end did not stop the press");

    chk_free_restart: assert property (
        pol_none && !permit_q && in_q.main_ok && start_ok && run_rise
        |=> permit_q)
        else $error("policy none refused a restart");

    chk_pulse_window: assert property (
        seq_rearm_pulse ##0 (lock_q && !engage && !in_window)
        |=> lock_q)
        else $error("out-of-window rearm pulse cleared the lock");

    chk_locked_hold: assert property (
        lock_eff && !permit_q && !rearm_ok |=> !permit_q)
        else $error("permit rose while locked");

    chk_raise_cause: assert property (
        $rose(permit_q) |-> $past(run_rise && in_q.main_ok && !lock_eff))
        else $error("permit rose without its conditions");

    chk_run_stop: assert property (
        permit_q && (run_fall || main_low) |=> !permit_q)
        else $error("run fall or main loss did not stop the press");

    chk_pending_excl: assert property (
        !(permit_q && pending_q))
        else $error("permit and pending high together");

    chk_inv_main: assert property (
        ##1 main_n_q == !$past(in_q.main_ok))
        else $error("inverted main permit wrong");

    chk_always_lock: assert property (
        cfg_q.policy == `PSP_POL_ALWAYS && $stable(cfg_q) ##0 seq_stop
        |-> lock_q)
        else $error("policy always did not lock after a stop");

    chk_pending_show: assert property (
        pending_q |-> $past(in_q.main_ok) && $past(start_ok))
        else $error("pending shown without main permit");

    chk_run_lock: assert property (
        pol_run && permit_q && (run_fall || main_low) |=> lock_q)
        else $error("policy run/main did not lock after a stop");

    chk_top_lock: assert property (
        pol_top && permit_q && top_rise |=> lock_q)
        else $error("policy top/main did not lock after stroke end");

    chk_rearm_clear: assert property (
        rearm_ok && !engage |=> !lock_q)
        else $error("valid rearm pulse left the lock engaged");
endmodule

// ===== include/psp_cfg.svh
// Offsets, field positions, reset values and timing for the press permit.
// Assumes a 10 MHz aclk and a 32-bit AXI4-Lite register port.
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH

`define PSP_OFS_CTRL 12'h000
`define PSP_OFS_STATUS 12'h004
`define PSP_OFS_IRQ_STAT 12'h008
`define PSP_OFS_IRQ_MASK 12'h00c

`define PSP_POL_NONE 3'h1
`define PSP_POL_ALWAYS 3'h2
`define PSP_POL_RUN_MAIN 3'h3
`define PSP_POL_TOP_MAIN 3'h4

`define PSP_CTRL_RST 8'h02
`define PSP_MASK_RST 8'h00

`define PSP_ST_PERMIT 0
`define PSP_ST_PENDING 1
`define PSP_ST_MAIN_N 2
`define PSP_ST_LOCK 3
`define PSP_ST_INPUTS 8

`define PSP_EV_RAISED 0
`define PSP_EV_DROPPED 1
`define PSP_EV_LOCKED 2
`define PSP_EV_REARM_OK 3
`define PSP_EV_REARM_BAD 4
`define PSP_EV_W 5

`define PSP_CLK_HZ 10000000
`define PSP_CYC_PER_MS (`PSP_CLK_HZ / 1000)
`define PSP_MIN_SHORT_MS 100
`define PSP_MIN_LONG_MS 350
`define PSP_MAX_PULSE_MS 30000

`endif

// ===== include/psp_pkg.sv
// Types shared by the press permit logic and its bench.
// Assumes nothing beyond SystemVerilog packed structs.
package psp_pkg;

    // Field order mirrors the control register, policy in the low bits
    typedef struct packed {
        logic [1:0] rsvd;
        logic long_pulse;
        logic stroke_en;
        logic start_en;
        logic [2:0] policy;
    } psp_cfg_t;

    typedef struct packed {
        logic rearm;
        logic stroke_end;
        logic start_ok;
        logic main_ok;
        logic run_req;
    } psp_in_t;

endpackage

// ===== verif/psp_ctl_model.sv
// Operator controls and contact monitor outputs feeding the permit pins.
// Assumes the bench calls its tasks right after a rising edge of aclk.
`timescale 1ns/100ps

module psp_ctl_model (
    input wire logic aclk,
    output psp_pkg::psp_in_t pins
);
    import psp_pkg::*;

    initial pins = '0;

    // Five edges cover the synchroniser plus the registered outputs
    task automatic apply(input logic [4:0] v);
        @(posedge aclk);
        pins <= psp_in_t'(v);
        repeat (5) @(posedge aclk);
    endtask

    // High time in whole aclk cycles, then back low
    task automatic rearm(input int n);
        @(posedge aclk);
        pins.rearm <= 1'b1;
        repeat (n) @(posedge aclk);
        pins.rearm <= 1'b0;
        repeat (5) @(posedge aclk);
    endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the press permit block and its register port.
// Assumes pulse limits shrunk by parameter to 10, 20 and 100 cycles.
`timescale 1ns/100ps
`include "psp_cfg.svh"

module tb_top;
    import psp_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic press_permit, rearm_pending, main_permit_n;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb;
    psp_in_t pin_in;
    int error_cnt, total_checks;

    psp_top #(.MIN_SHORT_CYC(32'd10), .MIN_LONG_CYC(32'd20),
        .MAX_PULSE_CYC(32'd100)) i_psp_top (.aclk(aclk), .aresetn(aresetn),
        .pin_in(pin_in), .press_permit(press_permit),
        .rearm_pending(rearm_pending), .main_permit_n(main_permit_n),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    psp_ctl_model i_psp_ctl_model (.aclk(aclk), .pins(pin_in));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected {permit, pending, main_n}
    task chk_pins(input logic [2:0] e);
        chk({29'h0, press_permit, rearm_pending, main_permit_n}, {29'h0, e});
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // No cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({31'h0, bvalid}, 32'h1);
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk({31'h0, rvalid}, 32'h1);
        chk({30'h0, rresp}, {30'h0, er});
        if (er == 2'b00) chk(rdata, e);
    endtask

    task results();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        results();
    end

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk_pins(3'b001);
        rd(`PSP_OFS_CTRL, 32'h02, 2'b00);
        rd(`PSP_OFS_IRQ_MASK, 32'h00, 2'b00);
        i_psp_ctl_model.apply(5'h02);
        chk_pins(3'b010);
        i_psp_ctl_model.apply(5'h03);
        chk_pins(3'b010);
        i_psp_ctl_model.apply(5'h02);
        i_psp_ctl_model.rearm(5);
        chk_pins(3'b010);
        i_psp_ctl_model.rearm(130);
        chk_pins(3'b010);
        i_psp_ctl_model.rearm(15);
        chk_pins(3'b000);
        i_psp_ctl_model.apply(5'h03);
        chk_pins(3'b100);
        i_psp_ctl_model.apply(5'h02);
        chk_pins(3'b010);
        wr(`PSP_OFS_CTRL, 32'h01, 2'b00);
        i_psp_ctl_model.apply(5'h03);
        chk_pins(3'b100);
        i_psp_ctl_model.apply(5'h02);
        chk_pins(3'b000);
        i_psp_ctl_model.apply(5'h03);
        chk_pins(3'b100);
        i_psp_ctl_model.apply(5'h01);
        chk_pins(3'b001);
        i_psp_ctl_model.apply(5'h00);
        wr(`PSP_OFS_CTRL, 32'h13, 2'b00);
        i_psp_ctl_model.apply(5'h02);
        chk_pins(3'b010);
        i_psp_ctl_model.rearm(15);
        i_psp_ctl_model.apply(5'h03);
        chk_pins(3'b100);
        i_psp_ctl_model.apply(5'h0b);
        chk_pins(3'b000);
        i_psp_ctl_model.apply(5'h0a);
        i_psp_ctl_model.apply(5'h0b);
        chk_pins(3'b100);
        i_psp_ctl_model.apply(5'h0a);
        chk_pins(3'b010);
        wr(`PSP_OFS_CTRL, 32'h3c, 2'b00);
        i_psp_ctl_model.apply(5'h0a);
        chk_pins(3'b000);
        i_psp_ctl_model.apply(5'h0e);
        chk_pins(3'b010);
        i_psp_ctl_model.rearm(15);
        chk_pins(3'b010);
        i_psp_ctl_model.rearm(25);
        chk_pins(3'b000);
        i_psp_ctl_model.apply(5'h0a);
        i_psp_ctl_model.apply(5'h0b);
        chk_pins(3'b000);
        i_psp_ctl_model.apply(5'h0a);
        i_psp_ctl_model.apply(5'h0e);
        i_psp_ctl_model.apply(5'h0f);
        chk_pins(3'b100);
        i_psp_ctl_model.apply(5'h0b);
        chk_pins(3'b100);
        i_psp_ctl_model.apply(5'h0a);
        i_psp_ctl_model.apply(5'h0e);
        chk_pins(3'b000);
        i_psp_ctl_model.apply(5'h0f);
        i_psp_ctl_model.apply(5'h07);
        chk_pins(3'b100);
        i_psp_ctl_model.apply(5'h0f);
        chk_pins(3'b010);
        rd(`PSP_OFS_IRQ_STAT, 32'h1f, 2'b00);
        chk({31'h0, irq}, 32'h0);
        wr(`PSP_OFS_IRQ_MASK, 32'h04, 2'b00);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(`PSP_OFS_IRQ_STAT, 32'h1f, 2'b00);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd(`PSP_OFS_IRQ_STAT, 32'h00, 2'b00);
        // Status is read-only, the write must leave it untouched
        wr(`PSP_OFS_STATUS, 32'h0, 2'b00);
        rd(`PSP_OFS_STATUS, 32'h0f0a, 2'b00);
        rd(12'h010, 32'h0, 2'b10);
        wr(12'h006, 32'h0, 2'b10);
        // Byte lanes: an unselected lane must keep the control byte
        wstrb <= 4'h2;
        wr(`PSP_OFS_CTRL, 32'h01, 2'b00);
        rd(`PSP_OFS_CTRL, 32'h3c, 2'b00);
        wstrb <= 4'h1;
        wr(`PSP_OFS_CTRL, 32'hffffff01, 2'b00);
        rd(`PSP_OFS_CTRL, 32'h01, 2'b00);
        results();
    end
endmodule
